// >>> hdl/swbm_master.sv
// Single-wire bus master: register port, slot sequencer and line driver.
`timescale 1ns/1ps
`default_nettype none

module swbm_master (
   input wire logic i_mclk,
   input wire logic i_rstn,
   input wire logic [swbm_pkg::ADDR_W-1:0] i_addr,
   input wire logic [swbm_pkg::DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [swbm_pkg::DATA_W-1:0] o_rdata,
   output logic o_irq,
   input wire logic i_line,
   output logic o_line_out,
   output logic o_line_oe
);

   ////////////////////////////////////////////////////////////////////////////
   // State.

   typedef struct packed {
      swbm_pkg::swbm_state_type state;
      logic [swbm_pkg::US_W-1:0] us_cnt;
      logic [swbm_pkg::CMD_W-1:0] cmd;
      logic presence;
      logic read_bit;
      logic [7:0] ratio;
      logic [swbm_pkg::CMD_W-1:0] irq_status;
      logic [swbm_pkg::CMD_W-1:0] irq_mask;
      logic [swbm_pkg::DATA_W-1:0] rdata;
      logic irq;
      logic line_oe;
      logic line_out;
      logic sync1;
      logic sync2;
   } swbm_regs_type;

   swbm_regs_type s_q;
   swbm_regs_type s_d;
   logic tick;
   logic restart;

   // The 10 MHz floor is met with margin: 125 clocks per microsecond.
   swbm_tick_div u_tick_div (
      .i_mclk(i_mclk),
      .i_rstn(i_rstn),
      .i_ratio(s_q.ratio),
      .i_restart(restart),
      .o_tick(tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Helpers.

   // True on the tick that closes a phase of the given length.
   function automatic logic phase_end(
      input logic t,
      input logic [swbm_pkg::US_W-1:0] cnt,
      input logic [swbm_pkg::US_W-1:0] len
   );
      phase_end = t && (cnt == len - 10'd1);
   endfunction : phase_end

   function automatic logic [swbm_pkg::DATA_W-1:0] ctrl_view(
      input swbm_regs_type r
   );
      logic [swbm_pkg::DATA_W-1:0] v;
      v = '0;
      v[swbm_pkg::CMD_W-1:0] = r.cmd;
      v[swbm_pkg::PRESENCE_FLAG_BIT] = r.presence;
      v[swbm_pkg::READ_RESULT_BIT] = r.read_bit;
      v[swbm_pkg::BUSY_BIT] = (r.state != swbm_pkg::ST_IDLE);
      ctrl_view = v;
   endfunction : ctrl_view

   // The divider restarts on each launch so every slot's first microsecond
   // is whole; otherwise a slot could lose up to one tick at its start.
   assign restart = (s_q.state == swbm_pkg::ST_IDLE);

   ////////////////////////////////////////////////////////////////////////////
   // Next state.

   always_comb begin
      logic [swbm_pkg::CMD_W-1:0] done;
      logic [swbm_pkg::CMD_W-1:0] clr;
      logic wr_hit_ctrl;
      done = '0;
      clr = '0;
      wr_hit_ctrl = i_wr && (i_addr == swbm_pkg::CTRL_ADDR);
      s_d = s_q;

      // Line input crosses into the clock domain before any use.
      s_d.sync1 = i_line;
      s_d.sync2 = s_q.sync1;

      if (tick) begin
         s_d.us_cnt = s_q.us_cnt + 10'd1;
      end

      unique case (s_q.state)
         swbm_pkg::ST_IDLE: begin
            s_d.us_cnt = '0;
            // Reset has priority over the two slot kinds.
            if (s_q.cmd[swbm_pkg::RESET_PRESENCE_CMD_BIT]) begin
               s_d.state = swbm_pkg::ST_RST_LOW;
            end else if (s_q.cmd[swbm_pkg::WRITE_ZERO_CMD_BIT]) begin
               s_d.state = swbm_pkg::ST_ZERO_LOW;
            end else if (s_q.cmd[swbm_pkg::WRITE_ONE_READ_CMD_BIT]) begin
               s_d.state = swbm_pkg::ST_READ_LOW;
            end
         end
         swbm_pkg::ST_RST_LOW: begin
            if (phase_end(tick, s_q.us_cnt, swbm_pkg::RESET_LOW_US)) begin
               s_d.state = swbm_pkg::ST_RST_HIGH;
               s_d.us_cnt = '0;
            end
         end
         swbm_pkg::ST_RST_HIGH: begin
            // A slave answer lands 15-60 us after release and lasts at
            // least 60 us, so the 68 us point always falls inside it.
            if (phase_end(tick, s_q.us_cnt, swbm_pkg::PRESENCE_US)) begin
               s_d.presence = ~s_q.sync2;
            end
            if (phase_end(tick, s_q.us_cnt, swbm_pkg::RESET_HIGH_US)) begin
               s_d.state = swbm_pkg::ST_IDLE;
               done[swbm_pkg::RESET_PRESENCE_CMD_BIT] = 1'b1;
            end
         end
         swbm_pkg::ST_ZERO_LOW: begin
            if (phase_end(tick, s_q.us_cnt, swbm_pkg::ZERO_LOW_US)) begin
               s_d.state = swbm_pkg::ST_ZERO_HIGH;
               s_d.us_cnt = '0;
            end
         end
         swbm_pkg::ST_ZERO_HIGH: begin
            if (phase_end(tick, s_q.us_cnt,
                swbm_pkg::ZERO_SLOT_US - swbm_pkg::ZERO_LOW_US)) begin
               s_d.state = swbm_pkg::ST_IDLE;
               done[swbm_pkg::WRITE_ZERO_CMD_BIT] = 1'b1;
            end
         end
         swbm_pkg::ST_READ_LOW: begin
            // The falling edge here is what the slave times from.
            if (phase_end(tick, s_q.us_cnt, swbm_pkg::READ_LOW_US)) begin
               s_d.state = swbm_pkg::ST_READ_HIGH;
               s_d.us_cnt = '0;
            end
         end
         swbm_pkg::ST_READ_HIGH: begin
            // A slave returning zero keeps the line low past release.
            if (phase_end(tick, s_q.us_cnt,
                swbm_pkg::READ_SAMPLE_US - swbm_pkg::READ_LOW_US)) begin
               s_d.read_bit = s_q.sync2;
            end
            if (phase_end(tick, s_q.us_cnt,
                swbm_pkg::READ_SLOT_US - swbm_pkg::READ_LOW_US)) begin
               s_d.state = swbm_pkg::ST_IDLE;
               done[swbm_pkg::WRITE_ONE_READ_CMD_BIT] = 1'b1;
            end
         end
         default: begin
            s_d.state = swbm_pkg::ST_IDLE;
            s_d.us_cnt = '0;
         end
      endcase

      // Line driver: open drain, pulled low only in the low phases.
      s_d.line_out = 1'b0;
      s_d.line_oe = (s_d.state == swbm_pkg::ST_RST_LOW) ||
                    (s_d.state == swbm_pkg::ST_ZERO_LOW) ||
                    (s_d.state == swbm_pkg::ST_READ_LOW);

      // Commands wait in their bits until the sequencer is free; a set
      // written in the cycle of completion wins over the auto-clear.
      s_d.cmd = s_q.cmd & ~done;
      if (wr_hit_ctrl) begin
         s_d.cmd = s_d.cmd | i_wdata[swbm_pkg::CMD_W-1:0];
      end

      if (i_wr && (i_addr == swbm_pkg::DIV_ADDR)) begin
         s_d.ratio = i_wdata;
      end
      if (i_wr && (i_addr == swbm_pkg::IRQ_MASK_ADDR)) begin
         s_d.irq_mask = i_wdata[swbm_pkg::CMD_W-1:0];
      end

      // Read data stands for the one cycle after the strobe.
      s_d.rdata = '0;
      if (i_rd) begin
         unique case (i_addr)
            swbm_pkg::CTRL_ADDR: s_d.rdata = ctrl_view(s_q);
            swbm_pkg::DIV_ADDR: s_d.rdata = s_q.ratio;
            swbm_pkg::IRQ_STATUS_ADDR: begin
               s_d.rdata = {{(swbm_pkg::DATA_W-swbm_pkg::CMD_W){1'b0}},
                            s_q.irq_status};
               clr = s_q.irq_status;
            end
            swbm_pkg::IRQ_MASK_ADDR: begin
               s_d.rdata = {{(swbm_pkg::DATA_W-swbm_pkg::CMD_W){1'b0}},
                            s_q.irq_mask};
            end
            default: s_d.rdata = '0;
         endcase
      end

      // Completion events are sticky; a new event beats a read-clear.
      s_d.irq_status = (s_q.irq_status & ~clr) | done;
      s_d.irq = |(s_d.irq_status & s_d.irq_mask);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers.

   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         s_q.state <= swbm_pkg::ST_IDLE;
         s_q.us_cnt <= '0;
         s_q.cmd <= '0;
         s_q.presence <= 1'b0;
         s_q.read_bit <= 1'b0;
         s_q.ratio <= swbm_pkg::DIV_RESET;
         s_q.irq_status <= '0;
         s_q.irq_mask <= swbm_pkg::IRQ_MASK_RESET;
         s_q.rdata <= '0;
         s_q.irq <= 1'b0;
         s_q.line_oe <= 1'b0;
         s_q.line_out <= 1'b0;
         s_q.sync1 <= 1'b1;
         s_q.sync2 <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_rdata = s_q.rdata;
   assign o_irq = s_q.irq;
   assign o_line_out = s_q.line_out;
   assign o_line_oe = s_q.line_oe;

endmodule : swbm_master

`default_nettype wire

// >>> hdl/swbm_pkg.sv
// Constants, register map and state encoding of the single-wire bus master.
package swbm_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Clock and tick.

   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned TICK_HZ = 1_000_000;
   localparam int unsigned MIN_CLK_HZ = 10_000_000;
   // Integer ratio; exact because the main clock is a multiple of 1 MHz.
   localparam logic [7:0] DIV_RESET = 8'(CLK_HZ / TICK_HZ);

   ////////////////////////////////////////////////////////////////////////////
   // Slot timing in microseconds, one tick each.

   localparam int unsigned US_W = 10;
   localparam logic [US_W-1:0] RESET_LOW_US = 10'd511;
   localparam logic [US_W-1:0] PRESENCE_US = 10'd68;
   localparam logic [US_W-1:0] RESET_HIGH_US = 10'd512;
   localparam logic [US_W-1:0] ZERO_LOW_US = 10'd100;
   localparam logic [US_W-1:0] ZERO_SLOT_US = 10'd117;
   localparam logic [US_W-1:0] READ_LOW_US = 10'd5;
   localparam logic [US_W-1:0] READ_SAMPLE_US = 10'd13;
   localparam logic [US_W-1:0] READ_SLOT_US = 10'd117;

   ////////////////////////////////////////////////////////////////////////////
   // Register map on the plain port.

   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 8;
   localparam logic [ADDR_W-1:0] CTRL_ADDR = 4'h0;
   localparam logic [ADDR_W-1:0] DIV_ADDR = 4'h4;
   localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 4'h8;
   localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 4'hC;

   // Control register fields; command bits share positions with events.
   localparam int unsigned RESET_PRESENCE_CMD_BIT = 0;
   localparam int unsigned WRITE_ZERO_CMD_BIT = 1;
   localparam int unsigned WRITE_ONE_READ_CMD_BIT = 2;
   localparam int unsigned PRESENCE_FLAG_BIT = 3;
   localparam int unsigned READ_RESULT_BIT = 4;
   localparam int unsigned BUSY_BIT = 5;
   localparam int unsigned CMD_W = 3;
   localparam logic [CMD_W-1:0] IRQ_MASK_RESET = 3'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer states, one-hot.

   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_RST_LOW = 7'h02,
      ST_RST_HIGH = 7'h04,
      ST_ZERO_LOW = 7'h08,
      ST_ZERO_HIGH = 7'h10,
      ST_READ_LOW = 7'h20,
      ST_READ_HIGH = 7'h40
   } swbm_state_type;

endpackage : swbm_pkg

// >>> hdl/swbm_tick_div.sv
// Integer clock divider that makes the one-microsecond sequencing tick.
`timescale 1ns/1ps
`default_nettype none

module swbm_tick_div (
   input wire logic i_mclk,
   input wire logic i_rstn,
   input wire logic [7:0] i_ratio,
   input wire logic i_restart,
   output logic o_tick
);

   typedef struct packed {
      logic [7:0] cnt;
      logic tick;
   } swbm_div_type;

   swbm_div_type s_q;
   swbm_div_type s_d;

   // A ratio of zero or one gives a tick on every clock.
   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      if (i_restart) begin
         s_d.cnt = 8'h00;
      end else if (s_q.cnt + 8'h01 >= i_ratio) begin
         s_d.cnt = 8'h00;
         s_d.tick = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + 8'h01;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_tick = s_q.tick;

endmodule : swbm_tick_div

`default_nettype wire

// >>> tb/swbm_monitor.sv
// Concurrent checks on the line driver and read port of the master.
`timescale 1ns/1ps
`default_nettype none

// Counts are in clocks: the bench runs the tick at one per clock.
module swbm_monitor (
   input wire logic i_mclk,
   input wire logic i_rstn,
   input wire logic i_rd,
   input wire logic [swbm_pkg::DATA_W-1:0] o_rdata,
   input wire logic o_line_out,
   input wire logic o_line_oe
);
   logic [9:0] hi_q;
   logic [9:0] lo_q;
   logic [9:0] last_q;

   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         hi_q <= 10'h000;
         lo_q <= 10'h3FF;
         last_q <= 10'h000;
      end else begin
         hi_q <= o_line_oe ? hi_q + 10'h001 : 10'h000;
         if (o_line_oe) begin
            lo_q <= 10'h000;
         end else if (lo_q != 10'h3FF) begin
            lo_q <= lo_q + 10'h001;
         end
         // A non-zero count with the enable now low marks a falling edge.
         if (!o_line_oe && hi_q != 10'h000) begin
            last_q <= hi_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rstn);

   drive_zero_a: assert property (o_line_out == 1'b0)
      else $error("line driven high");
   rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data outside answer cycle");
   pulse_width_a: assert property ($fell(o_line_oe) |->
      hi_q inside {[4:6], [99:101], [510:512]})
      else $error("low pulse width wrong");
   oe_hold_a: assert property ($rose(o_line_oe) |=> o_line_oe [*3])
      else $error("low pulse too short");
   read_gap_a: assert property ($rose(o_line_oe) &&
      last_q inside {[4:6]} |-> lo_q >= 10'd110)
      else $error("read slot too short");
   zero_gap_a: assert property ($rose(o_line_oe) &&
      last_q inside {[99:101]} |-> lo_q >= 10'd15)
      else $error("write-zero slot too short");
   reset_gap_a: assert property ($rose(o_line_oe) &&
      last_q inside {[510:512]} |-> lo_q >= 10'd510)
      else $error("reset recovery too short");
   oe_max_a: assert property (hi_q < 10'd514)
      else $error("line held low too long");

   cover property ($fell(o_line_oe) && hi_q inside {[4:6]});
   cover property ($fell(o_line_oe) && hi_q inside {[99:101]});
   cover property ($fell(o_line_oe) && hi_q inside {[510:512]});
endmodule : swbm_monitor
`default_nettype wire

// >>> tb/swbm_slave_model.sv
// Behavioural memory slave on the shared line, timed in clocks.
`timescale 1ns/1ps
`default_nettype none

module swbm_slave_model (
   input wire logic i_clk,
   input wire logic i_line,
   input wire logic i_present,
   input wire logic i_bit,
   input wire logic [7:0] i_wait,
   output logic o_pull
);
   int n;

   // Bit actions are timed from the master's falling edge; the presence pulse is timed from the release.
   initial begin
      o_pull = 1'b0;
      forever begin
         @(negedge i_line);
         if (i_present && !i_bit) begin
            o_pull <= 1'b1;
         end
         repeat (30) @(posedge i_clk);
         o_pull <= 1'b0;
         n = 30;
         while (!i_line) begin
            @(posedge i_clk);
            n++;
         end
         // A long low is a bus reset: answer with a presence pulse.
         if (n > 400 && i_present) begin
            repeat (i_wait) @(posedge i_clk);
            o_pull <= 1'b1;
            repeat (100) @(posedge i_clk);
            o_pull <= 1'b0;
         end
      end
   end
endmodule : swbm_slave_model
`default_nettype wire

// >>> tb/tb_swbm_master.sv
// Register-level testbench of the single-wire bus master.
`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
   err_count++; $display("ERROR %s exp %h got %h", n, e, g); end end

module tb_swbm_master;
   logic i_mclk;
   logic i_rstn;
   logic i_wr;
   logic i_rd;
   logic [swbm_pkg::ADDR_W-1:0] i_addr;
   logic [7:0] i_wdata;
   logic [7:0] o_rdata;
   logic o_irq;
   logic o_line_out;
   logic o_line_oe;
   logic pull;
   logic present;
   logic rbit;
   logic [7:0] dly;
   logic [7:0] v;
   wire logic line;
   int err_count;
   int cmp_count;
   int n;

   // Open-drain wire with a pull-up.
   assign line = (o_line_oe ? o_line_out : 1'b1) & !pull;

   swbm_master DUT (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .o_irq(o_irq), .i_line(line), .o_line_out(o_line_out),
      .o_line_oe(o_line_oe));
   swbm_slave_model u_slave (.i_clk(i_mclk), .i_line(line),
      .i_present(present), .i_bit(rbit), .i_wait(dly), .o_pull(pull));

   ////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge i_mclk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask : rd

   // Polling bounds the wait; the longest chain is about 1300 clocks.
   task automatic idle();
      n = 0;
      do begin
         rd(swbm_pkg::CTRL_ADDR, v);
         n++;
      end while ((v[5] || v[2:0] != 3'h0) && n < 3000);
      `CHK("idle", 1'b1, n < 3000)
   endtask : idle

   task automatic slot(input logic [7:0] c, ctl, st);
      wr(swbm_pkg::CTRL_ADDR, c);
      idle();
      `CHK("ctrl", ctl, v)
      `CHK("irq", 1'b1, o_irq)
      rd(swbm_pkg::IRQ_STATUS_ADDR, v);
      `CHK("status", st, v)
      @(posedge i_mclk);
      #1 `CHK("irq clr", 1'b0, o_irq)
   endtask : slot

   task automatic summarize();
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : summarize

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      i_mclk = 1'b0;
      forever #4 i_mclk = ~i_mclk;
   end

   initial begin
      repeat (40000) @(posedge i_mclk);
      err_count++;
      summarize();
   end

   initial begin
      i_rstn = 1'b0;
      {i_wr, i_rd, i_addr, i_wdata} = '0;
      {present, rbit, dly} = {2'h3, 8'h1E};
      {err_count, cmp_count} = '0;
      repeat (8) @(posedge i_mclk);
      i_rstn <= 1'b1;
      #1 `CHK("oe rst", 1'b0, o_line_oe)
      `CHK("irq rst", 1'b0, o_irq)
      rd(swbm_pkg::DIV_ADDR, v);
      `CHK("div", swbm_pkg::DIV_RESET, v)
      rd(swbm_pkg::IRQ_MASK_ADDR, v);
      `CHK("mask", 8'h00, v)
      rd(4'h2, v);
      `CHK("unmapped", 8'h00, v)
      // One tick per clock keeps the run short.
      wr(swbm_pkg::DIV_ADDR, 8'h01);
      wr(swbm_pkg::IRQ_MASK_ADDR, 8'h07);
      slot(8'h01, 8'h08, 8'h01);
      present <= 1'b0;
      slot(8'h01, 8'h00, 8'h01);
      {present, dly} <= {1'b1, 8'h3C};
      slot(8'h01, 8'h08, 8'h01);
      slot(8'h02, 8'h08, 8'h02);
      for (int b = 0; b < 2; b++) begin
         rbit <= b[0];
         slot(8'h04, {3'h0, b[0], 4'h8}, 8'h04);
      end
      rbit <= 1'b0;
      slot(8'h07, 8'h08, 8'h07);
      wr(swbm_pkg::IRQ_MASK_ADDR, 8'h00);
      wr(swbm_pkg::CTRL_ADDR, 8'h02);
      idle();
      @(posedge i_mclk);
      #1 `CHK("irq masked", 1'b0, o_irq)
      rd(swbm_pkg::IRQ_STATUS_ADDR, v);
      `CHK("status masked", 8'h02, v)
      summarize();
   end
endmodule : tb_swbm_master

bind swbm_master swbm_monitor u_mon (.i_mclk(i_mclk), .i_rstn(i_rstn),
   .i_rd(i_rd), .o_rdata(o_rdata), .o_line_out(o_line_out),
   .o_line_oe(o_line_oe));
`default_nettype wire
